// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wwr_pkg::*;
  localparam int SU = 20;
  localparam int PU = 5;
  localparam int PL = 3;
  localparam int T = TICK_CYC;
  logic core_clk, rst_b, fire, sel, lowV, misR, misF, regWr, regRd, clrPin;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, v, seed;
  logic primary_reset_out_n, secondary_reset_out_n, fault_flag_out_n;
  int fails, n_checks, n, i;

  wwr_supervisor #(.STARTUP_US(SU), .POR_US(PU), .PULSE_US(PL)) wwr_supervisor_inst (
    .core_clk(core_clk), .rst_b(rst_b), .clear_pulse_in(clrPin),
    .supervisor_select_pin(sel), .mainRegLowVolt(lowV),
    .primaryPinLevel(primary_reset_out_n ^ misR), .secondaryPinLevel(secondary_reset_out_n),
    .faultPinLevel(fault_flag_out_n ^ misF), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .primary_reset_out_n(primary_reset_out_n), .secondary_reset_out_n(secondary_reset_out_n),
    .fault_flag_out_n(fault_flag_out_n));
  wwr_host_model wwr_host_model_inst (.core_clk(core_clk), .rst_b(rst_b), .fire(fire),
    .clear_pulse_in(clrPin));

  always #2 core_clk = ~core_clk;

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return primary_reset_out_n;
      1: return secondary_reset_out_n;
      default: return fault_flag_out_n;
    endcase
  endfunction

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t register value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t output level %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdf(input logic [7:0] a, input int lo, input int w, output logic [31:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = (regRdata >> lo) & ((32'h1 << w) - 32'h1);
  endtask

  // bounded wait for an output to reach a level; count tells when it got there
  task automatic waitFor(input int w, input logic lv, input int maxc, output int c);
    c = 0;
    while (c < maxc) begin
      @(posedge core_clk);
      #1;
      c++;
      if (pick(w) === lv) break;
    end
    chkPin(pick(w), lv);
  endtask

  task automatic clr(input int us);
    cyc(us * T);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask

  task automatic doReset();
    rst_b <= 1'b0;
    cyc(12);
    rst_b <= 1'b1;
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // longest path is five start-up expiries plus the earlier steps, about 77k cycles
  initial begin
    cyc(95000);
    fails++;
    close_out();
  end

  initial begin
    core_clk = 0; rst_b = 0; fire = 0; sel = 0; lowV = 0; misR = 0; misF = 0;
    regWr = 0; regRd = 0; regAddr = '0; regWdata = '0; seed = 32'h9af9;
    cyc(5);
    chkPin(primary_reset_out_n, 1'b0);
    cyc(7);
    rst_b <= 1'b1;
    waitFor(2, 1'b1, 20, n);
    rdf(OFS_CTRL, 0, 32, v); chkReg(v, {30'h0, CTRL_RST});
    rdf(OFS_WINMIN, 0, 32, v); chkReg(v, {16'h0, WINMIN_RST});
    rdf(OFS_WINMAX, 0, 32, v); chkReg(v, {16'h0, WINMAX_RST});
    rdf(OFS_STATUS, 0, 32, v); chkReg(v, 32'h0);
    seed = lfsrNext(seed);
    wr(8'h14, seed);
    rdf(8'h14, 0, 32, v); chkReg(v, 32'h0);
    waitFor(0, 1'b1, (PU + 1) * T + 40, n);
    chkPin(n >= (PU - 1) * T, 1'b1);
    chkPin(secondary_reset_out_n, 1'b0);
    // shrink the window to 4..12 us and turn fast detection off
    wr(OFS_WINMIN, 32'h4);
    wr(OFS_WINMAX, 32'hc);
    wr(OFS_CTRL, 32'h0);
    rdf(OFS_WINMAX, 0, 32, v); chkReg(v, 32'hc);
    rdf(OFS_STATE, 9, 2, v); chkReg(v, 32'h1);
    clr(2);
    cyc(10);
    rdf(OFS_STATE, 9, 2, v); chkReg(v, 32'h2);
    chkPin(secondary_reset_out_n, 1'b0);
    for (i = 0; i < 12; i++) begin
      seed = lfsrNext(seed);
      clr(1 + int'(seed[0]));
    end
    cyc(10);
    chkPin(secondary_reset_out_n, 1'b1);
    rdf(OFS_STATUS, 0, 32, v); chkReg(v, 32'h0);
    // fast detection on: nine early clears are tolerated, the tenth trips
    wr(OFS_CTRL, 32'h1);
    for (i = 0; i < 9; i++) clr(2);
    cyc(10);
    rdf(OFS_STATE, 5, 4, v); chkReg(v, 32'h9);
    chkPin(primary_reset_out_n, 1'b1);
    clr(2);
    waitFor(0, 1'b0, 60, n);
    chkPin(secondary_reset_out_n, 1'b0);
    cyc(2);
    chkPin(fault_flag_out_n, 1'b0);
    rdf(OFS_STATUS, 1, 1, v); chkReg(v, 32'h1);
    rdf(OFS_STATE, 2, 3, v); chkReg(v, 32'h1);
    waitFor(0, 1'b1, (PL + PU + 1) * T + 40, n);
    wr(OFS_STATUS, 32'h3f);
    cyc(5);
    chkPin(fault_flag_out_n, 1'b1);
    clr(6);
    cyc(10);
    rdf(OFS_STATE, 2, 3, v); chkReg(v, 32'h0);
    waitFor(0, 1'b0, 14 * T, n);
    // first tick after the clear may land at once, and the wait starts a few cycles late
    chkPin(n >= 11 * T - 10, 1'b1);
    rdf(OFS_STATUS, 0, 1, v); chkReg(v, 32'h1);
    waitFor(0, 1'b1, (PL + PU + 1) * T + 40, n);
    wr(OFS_STATUS, 32'h3f);
    // latched mode: the next error keeps both resets low
    wr(OFS_CTRL, 32'h3);
    waitFor(0, 1'b0, (SU + 2) * T, n);
    cyc((PL + PU + 3) * T);
    chkPin(primary_reset_out_n, 1'b0);
    rdf(OFS_STATE, 12, 1, v); chkReg(v, 32'h1);
    // select high: no watchdog, no start-up wait, secondary held low
    sel <= 1'b1;
    doReset();
    waitFor(0, 1'b1, (PU + 1) * T + 40, n);
    cyc((SU + 4) * T);
    chkPin(primary_reset_out_n, 1'b1);
    clr(2);
    cyc(10);
    chkPin(secondary_reset_out_n, 1'b0);
    rdf(OFS_STATE, 9, 2, v); chkReg(v, 32'h0);
    sel <= 1'b0;
    doReset();
    waitFor(0, 1'b1, (PU + 1) * T + 40, n);
    // pin readback faults
    misF <= 1'b1;
    cyc(20);
    misF <= 1'b0;
    chkPin(fault_flag_out_n, 1'b0);
    rdf(OFS_STATUS, 4, 1, v); chkReg(v, 32'h1);
    wr(OFS_STATUS, 32'h3f);
    cyc(5);
    chkPin(fault_flag_out_n, 1'b1);
    misR <= 1'b1;
    cyc(20);
    misR <= 1'b0;
    chkPin(primary_reset_out_n, 1'b0);
    chkPin(fault_flag_out_n, 1'b0);
    rdf(OFS_STATUS, 3, 1, v); chkReg(v, 32'h1);
    wr(OFS_STATUS, 32'h3f);
    waitFor(0, 1'b1, (PU + 1) * T + 40, n);
    // regulator drop and a brief recovery
    lowV <= 1'b1;
    waitFor(0, 1'b0, 20, n);
    chkPin(secondary_reset_out_n, 1'b0);
    cyc(T);
    lowV <= 1'b0;
    waitFor(0, 1'b1, (PU + 1) * T + 40, n);
    chkPin(n >= (PU - 1) * T, 1'b1);
    rdf(OFS_STATUS, 5, 1, v); chkReg(v, 32'h1);
    // silent host: five start-up expiries latch the resets
    cyc(5 * (SU + PL + PU + 2) * T);
    chkPin(primary_reset_out_n, 1'b0);
    rdf(OFS_STATE, 12, 1, v); chkReg(v, 32'h1);
    rdf(OFS_STATE, 2, 3, v); chkReg(v, 32'h5);
    close_out();
  end
endmodule // tb
`default_nettype wire

// File: wwr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: sends one clear pulse of fixed width each time the bench fires
module wwr_host_model (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // power-on reset, active low
  input wire logic fire, // one-cycle request for a clear pulse
  output logic clear_pulse_in // clear pin, driven low when idle
);
  int hiLeft;

  // pulse stays high several cycles so the two-flop synchroniser sees it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiLeft <= 0;
      clear_pulse_in <= 1'b0;
    end else begin
      hiLeft <= fire ? 6 : (hiLeft > 0 ? hiLeft - 1 : 0);
      clear_pulse_in <= fire || (hiLeft > 1);
    end
  end
endmodule // wwr_host_model
`default_nettype wire

// File: wwr_pkg.sv
package wwr_pkg;
  // core clock and the microsecond tick derived from it
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  // supervision times in microsecond ticks
  localparam int STARTUP_MS = 256;
  localparam int STARTUP_US_DEF = STARTUP_MS * 1000;
  localparam int POR_DELAY_US_DEF = 10000;
  localparam int WDT_PULSE_US_DEF = 1000;

  // event limits
  localparam logic [2:0] RST_LIMIT = 3'h5;
  localparam logic [3:0] FAST_LIMIT = 4'ha;
  localparam logic [3:0] MON_FILT_CYC = 4'h8;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WINMIN = 8'h04;
  localparam logic [7:0] OFS_WINMAX = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;

  // control fields and reset values
  localparam int CTRL_FAST_EN = 0;
  localparam int CTRL_LATCH = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] WINMIN_RST = 16'h000a;
  localparam logic [15:0] WINMAX_RST = 16'h0064;

  // status bit positions
  localparam int ST_SLOW = 0;
  localparam int ST_FAST = 1;
  localparam int ST_START = 2;
  localparam int ST_RSTMON = 3;
  localparam int ST_DIAGMON = 4;
  localparam int ST_LOWV = 5;
  localparam int ST_W = 6;

  typedef enum logic [1:0] {WD_OFF, WD_WAIT, WD_MON} wwr_mode_e;
endpackage

// File: wwr_supervisor.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module wwr_supervisor import wwr_pkg::*; #(
  parameter int STARTUP_US = STARTUP_US_DEF,
  parameter int POR_US = POR_DELAY_US_DEF,
  parameter int PULSE_US = WDT_PULSE_US_DEF
) (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // power-on reset, active low
  input wire logic clear_pulse_in, // host clear pulse pin
  input wire logic supervisor_select_pin, // high disables watchdog
  input wire logic mainRegLowVolt, // regulator low-voltage detect
  input wire logic primaryPinLevel, // primary reset pin readback
  input wire logic secondaryPinLevel, // secondary reset pin readback
  input wire logic faultPinLevel, // fault pin readback
  input wire logic [7:0] regAddr, // register byte address
  input wire logic [31:0] regWdata, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [31:0] regRdata, // read data, cycle after strobe
  output logic primary_reset_out_n, // primary reset, active low
  output logic secondary_reset_out_n, // secondary reset, active low
  output logic fault_flag_out_n // latched fault, active low
);
  localparam logic [19:0] STARTUP_LIM = 20'(STARTUP_US);
  localparam logic [19:0] POR_LIM = 20'(POR_US);
  localparam logic [19:0] PULSE_LIM = 20'(PULSE_US);

  logic [5:0] syncOut;
  logic ckSync, selSync, lowV, pinP, pinS, pinD, ckPrev, ckEdge;
  logic [7:0] tickCnt;
  logic tickEn;
  logic [1:0] ctrl;
  logic [15:0] winMin, winMax;
  logic [ST_W-1:0] status;
  wwr_mode_e mode;
  logic [15:0] perCnt;
  logic [19:0] startCnt, porCnt, pulseCnt;
  logic [3:0] fastCnt, rstMonFilt, diagMonFilt;
  logic [2:0] rstCount;
  logic pulseActive, rstLatch, secondaryOk;
  logic rstHold, primaryInt, porDone, inMon, inWait;
  logic slowEvt, fastEvt, fastTrip, startExp, wdtErr, normalClr;
  logic rstMismatch, diagMismatch, rstMonSet, diagMonSet;
  logic [ST_W-1:0] statusSet;

  // the six input level pins cross two flops before any logic looks at them; the register port is used directly
  wwr_sync #(.W(6)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .din({clear_pulse_in, supervisor_select_pin, mainRegLowVolt,
          primaryPinLevel, secondaryPinLevel, faultPinLevel}),
    .dout(syncOut)
  );
  assign {ckSync, selSync, lowV, pinP, pinS, pinD} = syncOut;

  // rising edge of the synchronised clear input
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ckPrev <= 1'b0;
    end else begin
      ckPrev <= ckSync;
    end
  end
  assign ckEdge = ckSync & ~ckPrev;

  // microsecond enable; all supervision times count in ticks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt <= 8'h00;
    end else if (tickCnt == TICK_LAST) begin
      tickCnt <= 8'h00;
    end else begin
      tickCnt <= tickCnt + 8'h01;
    end
  end
  assign tickEn = (tickCnt == TICK_LAST);

  // anything that must keep the primary reset low
  assign rstHold = lowV | pulseActive | rstLatch | status[ST_RSTMON];
  assign porDone = (porCnt >= POR_LIM);
  assign primaryInt = porDone & ~rstHold;
  assign inMon = (mode == WD_MON);
  assign inWait = (mode == WD_WAIT);

  // por delay restarts each time the primary is pulled low
  wwr_timer #(.W(20)) u_por (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(rstHold),
    .inc(tickEn),
    .count(porCnt)
  );

  // start-up wait only runs while monitoring is not yet valid
  wwr_timer #(.W(20)) u_start (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(~inWait | ~primaryInt | ckEdge),
    .inc(tickEn),
    .count(startCnt)
  );

  // period since the last clear, too-fast ones included; held at zero while the primary is low
  wwr_timer #(.W(16)) u_period (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(~inMon | ckEdge | ~primaryInt | wdtErr | fastEvt | selSync),
    .inc(tickEn),
    .count(perCnt)
  );

  // width of a non-latched watchdog reset
  wwr_timer #(.W(20)) u_pulse (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(~pulseActive),
    .inc(tickEn),
    .count(pulseCnt)
  );

  // window classification; only judged while the host is out of reset
  assign slowEvt = inMon & primaryInt & (perCnt >= winMax);
  assign fastEvt = inMon & primaryInt & ckEdge & ctrl[CTRL_FAST_EN]
                   & (perCnt < winMin);
  assign normalClr = primaryInt & ckEdge & ~fastEvt & (inMon | inWait);
  assign fastTrip = fastEvt & (fastCnt == FAST_LIMIT - 4'h1);
  assign startExp = inWait & primaryInt & (startCnt >= STARTUP_LIM);
  assign wdtErr = slowEvt | fastTrip | startExp;

  // monitoring mode: invalid after por, valid on a clear in the wait
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= WD_WAIT;
    end else if (selSync) begin
      mode <= WD_OFF;
    end else begin
      unique case (mode)
        WD_OFF: mode <= WD_WAIT;
        WD_WAIT: if (normalClr) begin
          mode <= WD_MON;
        end
        WD_MON: if (lowV) begin
          mode <= WD_WAIT;
        end
      endcase
    end
  end

  // consecutive too-fast count, broken by any accepted clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fastCnt <= 4'h0;
    end else if (normalClr | ~inMon | fastTrip) begin
      fastCnt <= 4'h0;
    end else if (fastEvt) begin
      fastCnt <= fastCnt + 4'h1;
    end
  end

  // watchdog reset count; frozen once it latches
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstCount <= 3'h0;
    end else if (rstLatch) begin
      rstCount <= rstCount;
    end else if (wdtErr) begin
      rstCount <= rstCount + 3'h1;
    end else if (normalClr | selSync) begin
      rstCount <= 3'h0;
    end
  end

  // off-latch is left only by power-on reset, select cannot free it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstLatch <= 1'b0;
    end else if (wdtErr & (ctrl[CTRL_LATCH] | (rstCount == RST_LIMIT - 3'h1))) begin
      rstLatch <= 1'b1;
    end
  end

  // pulsed watchdog reset, followed by a full por delay
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulseActive <= 1'b0;
    end else if (wdtErr) begin
      pulseActive <= 1'b1;
    end else if (pulseCnt >= PULSE_LIM) begin
      pulseActive <= 1'b0;
    end
  end

  // secondary released by the first accepted clear after monitoring becomes valid
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      secondaryOk <= 1'b0;
    end else if (wdtErr | selSync | rstHold | ~inMon) begin
      secondaryOk <= 1'b0;
    end else if (normalClr) begin
      secondaryOk <= 1'b1;
    end
  end

  // pin readback; a short filter covers output-to-pin latency
  assign rstMismatch = (pinP != primary_reset_out_n) | (pinS != secondary_reset_out_n);
  assign diagMismatch = (pinD != fault_flag_out_n);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMonFilt <= 4'h0;
      diagMonFilt <= 4'h0;
    end else begin
      rstMonFilt <= rstMismatch ? (rstMonSet ? rstMonFilt : rstMonFilt + 4'h1) : 4'h0;
      diagMonFilt <= diagMismatch ? (diagMonSet ? diagMonFilt : diagMonFilt + 4'h1) : 4'h0;
    end
  end
  assign rstMonSet = (rstMonFilt == MON_FILT_CYC);
  assign diagMonSet = (diagMonFilt == MON_FILT_CYC);

  // sticky abnormality record
  always_comb begin
    statusSet = '0;
    statusSet[ST_SLOW] = slowEvt;
    statusSet[ST_FAST] = fastTrip;
    statusSet[ST_START] = startExp;
    statusSet[ST_RSTMON] = rstMonSet;
    statusSet[ST_DIAGMON] = diagMonSet;
    statusSet[ST_LOWV] = lowV;
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
    end else if (regWr && (regAddr == OFS_STATUS)) begin
      status <= (status & ~regWdata[ST_W-1:0]) | statusSet;
    end else begin
      status <= status | statusSet;
    end
  end

  // software-written configuration
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      winMin <= WINMIN_RST;
      winMax <= WINMAX_RST;
    end else if (regWr) begin
      unique case (regAddr)
        OFS_CTRL: ctrl <= regWdata[1:0];
        OFS_WINMIN: winMin <= regWdata[15:0];
        OFS_WINMAX: winMax <= regWdata[15:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_CTRL: regRdata <= {30'h0000_0000, ctrl};
        OFS_WINMIN: regRdata <= {16'h0000, winMin};
        OFS_WINMAX: regRdata <= {16'h0000, winMax};
        OFS_STATUS: regRdata <= {26'h000_0000, status};
        OFS_STATE: regRdata <= {19'h0_0000, rstLatch, secondaryOk, mode,
                                fastCnt, rstCount, pulseActive, primaryInt};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // pin drivers; fault stays low until causes end and record is cleared
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_reset_out_n <= 1'b0;
      secondary_reset_out_n <= 1'b0;
      fault_flag_out_n <= 1'b0;
    end else begin
      primary_reset_out_n <= primaryInt;
      secondary_reset_out_n <= primaryInt & secondaryOk & ~selSync;
      fault_flag_out_n <= ~((|status) | (|statusSet));
    end
  end

  sequence seqBothLow;
    !primary_reset_out_n && !secondary_reset_out_n;
  endsequence

  sequence seqFaultLow;
    !fault_flag_out_n;
  endsequence

  AST_SLOW_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    slowEvt |-> ##2 (seqBothLow and seqFaultLow))
    else $error("too-slow event did not pull resets and fault low");

  AST_FAST_GATED: assert property (@(posedge core_clk) disable iff (!rst_b)
    (inMon && primaryInt && ckEdge && !ctrl[CTRL_FAST_EN]) |=> (fastCnt == 4'h0))
    else $error("too-fast counted while detection disabled");

  AST_SELECT_SECONDARY: assert property (@(posedge core_clk) disable iff (!rst_b)
    selSync |=> !secondary_reset_out_n)
    else $error("secondary released while watchdog deselected");

  AST_LATCH_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_b)
    rstLatch |=> (rstLatch && !primary_reset_out_n && !secondary_reset_out_n))
    else $error("reset off-latch released");

  AST_FIFTH_LATCHES: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wdtErr && rstCount == RST_LIMIT - 3'h1) |=> rstLatch)
    else $error("fifth watchdog reset did not latch");

  AST_FAST_TEN: assert property (@(posedge core_clk) disable iff (!rst_b)
    fastTrip |-> ##2 (seqBothLow and seqFaultLow))
    else $error("tenth too-fast event did not reset");

  AST_PERIOD_REINIT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ckEdge || wdtErr || selSync) |=> (perCnt == 16'h0000))
    else $error("period counter not reinitialised");

  AST_STARTUP_VALID: assert property (@(posedge core_clk) disable iff (!rst_b)
    (inWait && normalClr && !selSync) |=> inMon)
    else $error("clear in start-up wait did not validate monitoring");

  AST_POR_DELAY: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(primary_reset_out_n) |-> ($past(porCnt) >= POR_LIM))
    else $error("primary released before full por delay");

  AST_LOWV_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    lowV |-> ##1 seqBothLow)
    else $error("regulator drop did not pull both resets low");

  AST_FAULT_RECORD: assert property (@(posedge core_clk) disable iff (!rst_b)
    (status != '0) |=> seqFaultLow)
    else $error("fault released with abnormality still recorded");
endmodule // wwr_supervisor
`default_nettype wire

// File: wwr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module wwr_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] din, // asynchronous levels
  output logic [W-1:0] dout // synchronised levels
);
  logic [W-1:0] stage1;

  // two flops; only the second stage reads the first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // wwr_sync
`default_nettype wire

// File: wwr_timer.sv
`timescale 1ns/100ps
`default_nettype none
module wwr_timer #(
  parameter int W = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic clr, // reinitialise to zero
  input wire logic inc, // count one step
  output logic [W-1:0] count // elapsed steps
);
  // saturates so a stuck host never wraps into a false window
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (inc && (count != '1)) begin
      count <= count + W'(1);
    end
  end
endmodule // wwr_timer
`default_nettype wire
